// >>> flash_isp_pkg.sv
// Shared constants and types of the flash programming sequencer
package flash_isp_pkg;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_MODE_CONTROL = 10'h0BF;
	localparam logic [9:0] IDX_UNLOCK_KEY   = 10'h0C1;
	localparam logic [9:0] IDX_ADDR_HIGH    = 10'h0C4;
	localparam logic [9:0] IDX_ADDR_LOW     = 10'h0C5;
	localparam logic [9:0] IDX_PROG_DATA    = 10'h0C6;
	localparam logic [9:0] IDX_OP_CONTROL   = 10'h0C7;
	localparam logic [9:0] IDX_STATUS       = 10'h0C8;

	// Unlock key values
	localparam logic [7:0] KEY_FIRST  = 8'h87;
	localparam logic [7:0] KEY_SECOND = 8'h59;

	// Flash mode control fields
	localparam int MODE_PROG_EN_BIT   = 0;
	localparam int MODE_BOOT_SEL_BIT  = 1;
	localparam int MODE_LOADER_BIT    = 5;
	localparam int MODE_SW_RESET_BIT  = 7;
	localparam logic [7:0] MODE_WRITE_MASK = 8'h9B;
	localparam logic [7:0] MODE_RESET      = 8'h00;

	// ROM operation control fields
	localparam int OPC_BANK_BIT = 6;
	localparam int OPC_OE_BIT   = 5;
	localparam int OPC_CE_BIT   = 4;
	localparam logic [7:0] OPC_WRITE_MASK = 8'h7F;
	localparam logic [7:0] OPC_RESET      = 8'h00;
	localparam logic [7:0] ADDR_RESET     = 8'h00;
	localparam logic [7:0] DATA_RESET     = 8'h00;

	// Operation codes
	localparam logic [3:0] OP_READ    = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_ERASE   = 4'h2;

	// Status fields
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_DONE_BIT   = 1;
	localparam int STAT_LOADER_BIT = 2;

	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	typedef struct packed {
		logic       bank;
		logic       oe;
		logic       ce;
		logic [3:0] op;
	} flash_cmd_s;

endpackage : flash_isp_pkg

// >>> flash_bank.sv
// Single-port byte-wide flash bank model with registered read data
`timescale 1ns/1ps
module flash_bank #(
	parameter int AW = 16
) (
	input  wire logic          hclk,
	input  wire logic          en,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [7:0]    wdata,
	output logic      [7:0]    rdata
);

	logic [7:0] mem [0:(1<<AW)-1];

	always_ff @(posedge hclk) begin
		if (en) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end

endmodule : flash_bank

// >>> flash_isp_sequencer.sv
// Flash in-system programming sequencer with AHB-Lite register access
// Contract
// R1 - Mode control writable only after both keys
// R2 - Any other key value relocks mode control
// R3 - Flash operations run only during CPU idle
// R4 - Bit 0 enters programming mode at wake-up
// R5 - Waking routine fetched from loader bank
// R6 - Program counter cleared on switch to loader
// R7 - Bits 0, 1, 7 set force software reset
// R8 - 64K application and 4K loader banks
// R9 - Software times idle to fit the operation
// R10 - Address from high and low byte registers
// R11 - Data register feeds program, receives read
// R12 - Operation bit 6 selects target bank
// R13 - Bits 3:0 opcode, 5 output/4 chip enable
// R14 - Erase: opcode 0010, OE one, CE zero
// R15 - Program: opcode 0001, OE one, CE zero
// R16 - Read: opcode 0000, OE and CE zero
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module flash_isp_sequencer #(
	parameter int APP_AW = 16,
	parameter int LDR_AW = 12
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        cpu_idle,
	input  wire logic        cpu_wake,
	input  wire logic [15:0] fetch_addr,
	output logic      [7:0]  fetch_data,
	output logic             loader_fetch,
	output logic             pc_clear,
	output logic             cpu_soft_reset,
	output logic             isp_busy
);

	typedef enum logic [1:0] {LK_LOCKED, LK_FIRST, LK_OPEN} lock_e;
	typedef enum logic [2:0] {
		FS_IDLE, FS_ERASE, FS_PROGRAM, FS_READ, FS_CAPTURE
	} fsm_e;

	lock_e      lock_reg;
	fsm_e       state_reg;
	logic [7:0] mode_reg;
	logic [7:0] addr_high_reg;
	logic [7:0] addr_low_reg;
	logic [7:0] data_reg;
	logic [7:0] opc_reg;
	logic       done_reg;
	logic       loader_reg;
	logic       idle_prev_reg;
	logic [APP_AW-1:0] erase_cnt_reg;
	logic       wr_pend_reg;
	logic [9:0] wr_idx_reg;
	logic [9:0] rd_idx_reg;
	logic [31:0] hrdata_reg;
	logic       hreadyout_reg;
	logic       pc_clear_reg;
	logic       soft_reset_reg;
	logic [7:0] fetch_data_reg;

	flash_isp_pkg::flash_cmd_s cmd;
	logic        wake_evt;
	logic        soft_clr;
	logic        start;
	logic [7:0]  wdat;
	logic [7:0]  rd_value;
	logic        app_en;
	logic        app_we;
	logic [APP_AW-1:0] app_addr;
	logic        ldr_en;
	logic        ldr_we;
	logic [LDR_AW-1:0] ldr_addr;
	logic [7:0]  mem_wdata;
	logic [7:0]  app_rdata;
	logic [7:0]  ldr_rdata;
	logic [APP_AW-1:0] erase_last;
	logic [15:0] target_addr;

	assign cmd = '{bank: opc_reg[flash_isp_pkg::OPC_BANK_BIT],
		oe: opc_reg[flash_isp_pkg::OPC_OE_BIT],
		ce: opc_reg[flash_isp_pkg::OPC_CE_BIT],
		op: opc_reg[3:0]}; // R13 R12
	assign target_addr = {addr_high_reg, addr_low_reg}; // R10
	assign wdat = hwdata[7:0];
	assign wake_evt = cpu_wake & cpu_idle;
	// Reset returns lock, mode, address, data, operation, done and bank select home; sequencer state is kept
	assign soft_clr = wake_evt
		& mode_reg[flash_isp_pkg::MODE_SW_RESET_BIT]
		& mode_reg[flash_isp_pkg::MODE_BOOT_SEL_BIT]
		& mode_reg[flash_isp_pkg::MODE_PROG_EN_BIT]; // R7
	// One operation per idle period, launched as the CPU goes idle
	assign start = cpu_idle & ~idle_prev_reg & (state_reg == FS_IDLE)
		& mode_reg[flash_isp_pkg::MODE_PROG_EN_BIT]; // R3
	assign erase_last = cmd.bank ? APP_AW'((1 << LDR_AW) - 1)
		: {APP_AW{1'b1}};

	// Bus slave: writes commit in the data phase, reads take one wait state
	// so that a write just before a read is already visible.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg   <= 1'b0;
			wr_idx_reg    <= '0;
			rd_idx_reg    <= '0;
			hreadyout_reg <= 1'b1;
			hrdata_reg    <= '0;
		end else begin
			wr_pend_reg   <= 1'b0;
			hreadyout_reg <= 1'b1;
			if (hready && hsel && htrans[1]) begin
				wr_pend_reg <= hwrite;
				wr_idx_reg  <= haddr[11:2];
				if (!hwrite) begin
					hreadyout_reg <= 1'b0;
					rd_idx_reg    <= haddr[11:2];
				end
			end
			if (!hreadyout_reg) begin
				hrdata_reg <= {24'h000000, rd_value};
			end
		end
	end

	always_comb begin
		case (rd_idx_reg)
		flash_isp_pkg::IDX_MODE_CONTROL:
			rd_value = mode_reg
				| {2'b00, loader_reg, 5'b00000};
		flash_isp_pkg::IDX_ADDR_HIGH:  rd_value = addr_high_reg;
		flash_isp_pkg::IDX_ADDR_LOW:   rd_value = addr_low_reg;
		flash_isp_pkg::IDX_PROG_DATA:  rd_value = data_reg;
		flash_isp_pkg::IDX_OP_CONTROL: rd_value = opc_reg;
		flash_isp_pkg::IDX_STATUS:
			rd_value = {5'b00000, loader_reg, done_reg,
				state_reg != FS_IDLE};
		default: rd_value = 8'h00;
		endcase
	end

	// Key sequence that opens the mode control register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_reg <= LK_LOCKED;
		end else if (soft_clr) begin
			lock_reg <= LK_LOCKED;
		end else if (wr_pend_reg
			&& wr_idx_reg == flash_isp_pkg::IDX_UNLOCK_KEY) begin
			if (wdat == flash_isp_pkg::KEY_FIRST) begin
				if (lock_reg != LK_OPEN) begin
					lock_reg <= LK_FIRST; // R1
				end
			end else if (wdat == flash_isp_pkg::KEY_SECOND) begin
				if (lock_reg == LK_FIRST) begin
					lock_reg <= LK_OPEN; // R1
				end else if (lock_reg != LK_OPEN) begin
					lock_reg <= LK_LOCKED;
				end
			end else begin
				lock_reg <= LK_LOCKED; // R2
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_reg <= flash_isp_pkg::MODE_RESET;
		end else if (soft_clr) begin
			mode_reg <= flash_isp_pkg::MODE_RESET;
		end else if (wr_pend_reg && lock_reg == LK_OPEN
			&& wr_idx_reg == flash_isp_pkg::IDX_MODE_CONTROL) begin
			mode_reg <= wdat & flash_isp_pkg::MODE_WRITE_MASK; // R1
		end
	end

	// Bank switch happens only at a wake-up from idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loader_reg     <= 1'b0; // R8
			pc_clear_reg   <= 1'b0;
			soft_reset_reg <= 1'b0;
		end else begin
			pc_clear_reg   <= 1'b0;
			soft_reset_reg <= soft_clr; // R7
			if (soft_clr) begin
				loader_reg <= 1'b0; // R8
			end else if (wake_evt && !loader_reg
				&& mode_reg[flash_isp_pkg::MODE_PROG_EN_BIT]) begin
				loader_reg   <= 1'b1; // R4 R5
				pc_clear_reg <= 1'b1; // R6
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_high_reg <= flash_isp_pkg::ADDR_RESET;
			addr_low_reg  <= flash_isp_pkg::ADDR_RESET;
			opc_reg       <= flash_isp_pkg::OPC_RESET;
		end else if (soft_clr) begin
			addr_high_reg <= flash_isp_pkg::ADDR_RESET;
			addr_low_reg  <= flash_isp_pkg::ADDR_RESET;
			opc_reg       <= flash_isp_pkg::OPC_RESET;
		end else if (wr_pend_reg) begin
			case (wr_idx_reg)
			flash_isp_pkg::IDX_ADDR_HIGH:  addr_high_reg <= wdat;
			flash_isp_pkg::IDX_ADDR_LOW:   addr_low_reg  <= wdat;
			flash_isp_pkg::IDX_OP_CONTROL:
				opc_reg <= wdat & flash_isp_pkg::OPC_WRITE_MASK;
			default: ;
			endcase
		end
	end

	// Read result wins over a software write to the data register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_reg <= flash_isp_pkg::DATA_RESET;
		end else if (soft_clr) begin
			data_reg <= flash_isp_pkg::DATA_RESET;
		end else if (state_reg == FS_CAPTURE) begin
			data_reg <= cmd.bank ? ldr_rdata : app_rdata; // R11 R16
		end else if (wr_pend_reg
			&& wr_idx_reg == flash_isp_pkg::IDX_PROG_DATA) begin
			data_reg <= wdat;
		end
	end

	// Done is sticky; completion in the clearing cycle keeps it set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_reg <= 1'b0;
		end else if (soft_clr) begin
			done_reg <= 1'b0;
		end else if ((state_reg == FS_ERASE && erase_cnt_reg == erase_last)
			|| state_reg == FS_PROGRAM || state_reg == FS_CAPTURE) begin
			done_reg <= 1'b1;
		end else if (wr_pend_reg && wr_idx_reg == flash_isp_pkg::IDX_STATUS
			&& wdat[flash_isp_pkg::STAT_DONE_BIT]) begin
			done_reg <= 1'b0;
		end
	end

	// Operation sequencer; unknown command combinations do nothing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg     <= FS_IDLE;
			erase_cnt_reg <= '0;
			idle_prev_reg <= 1'b0;
		end else begin
			idle_prev_reg <= cpu_idle;
			case (state_reg)
			FS_IDLE: begin
				erase_cnt_reg <= '0;
				if (start && cmd.oe && !cmd.ce) begin
					if (cmd.op == flash_isp_pkg::OP_ERASE) begin
						state_reg <= FS_ERASE; // R14
					end else if (cmd.op == flash_isp_pkg::OP_PROGRAM) begin
						state_reg <= FS_PROGRAM; // R15
					end
				end else if (start && !cmd.oe && !cmd.ce
					&& cmd.op == flash_isp_pkg::OP_READ) begin
					state_reg <= FS_READ; // R16
				end
			end
			FS_ERASE: begin
				erase_cnt_reg <= erase_cnt_reg + 1'b1;
				if (erase_cnt_reg == erase_last) begin
					state_reg <= FS_IDLE;
				end
			end
			FS_PROGRAM: state_reg <= FS_IDLE;
			FS_READ:    state_reg <= FS_CAPTURE;
			FS_CAPTURE: state_reg <= FS_IDLE;
			default:    state_reg <= FS_IDLE;
			endcase
		end
	end

	// Flash port steering: sequencer owns the banks during erase, program and read
	always_comb begin
		app_en    = 1'b1;
		app_we    = 1'b0;
		app_addr  = fetch_addr[APP_AW-1:0];
		ldr_en    = 1'b1;
		ldr_we    = 1'b0;
		ldr_addr  = fetch_addr[LDR_AW-1:0];
		mem_wdata = data_reg; // R11 R15
		case (state_reg)
		FS_ERASE: begin
			mem_wdata = flash_isp_pkg::ERASED_BYTE; // R14
			app_we    = !cmd.bank;
			ldr_we    = cmd.bank;
			app_addr  = erase_cnt_reg;
			ldr_addr  = erase_cnt_reg[LDR_AW-1:0];
		end
		FS_PROGRAM, FS_READ: begin
			app_we   = (state_reg == FS_PROGRAM) && !cmd.bank; // R12
			ldr_we   = (state_reg == FS_PROGRAM) && cmd.bank;
			app_addr = target_addr[APP_AW-1:0]; // R10
			ldr_addr = target_addr[LDR_AW-1:0];
		end
		default: ;
		endcase
	end

	flash_bank #(.AW(APP_AW)) u_app_bank (
		.hclk  (hclk),
		.en    (app_en),
		.we    (app_we),
		.addr  (app_addr),
		.wdata (mem_wdata),
		.rdata (app_rdata)
	); // R8

	flash_bank #(.AW(LDR_AW)) u_ldr_bank (
		.hclk  (hclk),
		.en    (ldr_en),
		.we    (ldr_we),
		.addr  (ldr_addr),
		.wdata (mem_wdata),
		.rdata (ldr_rdata)
	); // R8

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fetch_data_reg <= 8'h00;
		end else begin
			fetch_data_reg <= loader_reg ? ldr_rdata : app_rdata; // R5 R8
		end
	end

	assign hrdata         = hrdata_reg;
	assign hreadyout      = hreadyout_reg;
	assign hresp          = 1'b0;
	assign fetch_data     = fetch_data_reg;
	assign loader_fetch   = loader_reg;
	assign pc_clear       = pc_clear_reg;
	assign cpu_soft_reset = soft_reset_reg;
	assign isp_busy       = (state_reg != FS_IDLE);

endmodule : flash_isp_sequencer

// >>> flash_isp_monitor.sv
// Concurrent checks on the flash sequencer ports
`timescale 1ns/1ps
module flash_isp_monitor (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        cpu_idle,
	input wire logic        cpu_wake,
	input wire logic        loader_fetch,
	input wire logic        pc_clear,
	input wire logic        cpu_soft_reset,
	input wire logic        isp_busy
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_req;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait: assert property (rd_req |=> rd_answer)
		else $error("read wait state wrong");
	a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite
		|=> hreadyout) else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_read_pad: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	a_busy_idle: assert property (isp_busy |-> cpu_idle)
		else $error("operation outside idle");
	a_busy_entry: assert property ($rose(isp_busy) |->
		$past(cpu_idle) && !$past(cpu_idle, 2))
		else $error("start not at idle entry");
	a_switch_wake: assert property ($rose(loader_fetch) |->
		pc_clear && $past(cpu_wake) && $past(cpu_idle))
		else $error("bad bank switch");
	a_clear_pulse: assert property (pc_clear |=> !pc_clear)
		else $error("counter clear too long");
	a_soft_reset: assert property (cpu_soft_reset |-> !loader_fetch &&
		$past(cpu_wake) && $past(cpu_idle) ##1 !cpu_soft_reset)
		else $error("bad software reset");
	a_leave_loader: assert property ($fell(loader_fetch) |-> cpu_soft_reset)
		else $error("left loader without reset");
endmodule : flash_isp_monitor

bind flash_isp_sequencer flash_isp_monitor i_mon (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.cpu_idle(cpu_idle), .cpu_wake(cpu_wake), .loader_fetch(loader_fetch),
	.pc_clear(pc_clear), .cpu_soft_reset(cpu_soft_reset),
	.isp_busy(isp_busy));

// >>> cpu_model.sv
// CPU side model: idle entry, timed wake-up, idle exit
`timescale 1ns/1ps
module cpu_model #(
	parameter int NAP = 80
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic start,
	output logic      cpu_idle,
	output logic      cpu_wake
);
	logic [7:0] nap_reg;
	// Nap outlasts the longest operation run in the bench
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_idle <= 1'b0;
			cpu_wake <= 1'b0;
			nap_reg  <= 8'h00;
		end else begin
			cpu_wake <= cpu_idle && nap_reg == 8'h01;
			if (start && !cpu_idle) begin
				cpu_idle <= 1'b1;
				nap_reg  <= 8'(NAP);
			end else if (cpu_idle) begin
				if (nap_reg != 8'h00) nap_reg <= nap_reg - 8'h01;
				else cpu_idle <= 1'b0;
			end
		end
	end
endmodule : cpu_model

// >>> testbench.sv
// Register-level tests of the flash sequencer
`timescale 1ns/1ps
module testbench;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic        cpu_idle, cpu_wake, start, loader_fetch, pc_clear;
	logic        cpu_soft_reset, isp_busy;
	logic [15:0] fetch_addr;
	logic [7:0]  fetch_data, rd;
	int          miscompares, num_checks;

	flash_isp_sequencer #(.APP_AW(6), .LDR_AW(4)) i_dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.cpu_idle(cpu_idle), .cpu_wake(cpu_wake), .fetch_addr(fetch_addr),
		.fetch_data(fetch_data), .loader_fetch(loader_fetch),
		.pc_clear(pc_clear), .cpu_soft_reset(cpu_soft_reset),
		.isp_busy(isp_busy));
	cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .start(start),
		.cpu_idle(cpu_idle), .cpu_wake(cpu_wake));

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One single transfer; called just after a rising edge
	task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
		haddr  <= {20'h00000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata[7:0];
	endtask : xfer
	task automatic rchk(input logic [9:0] idx, input logic [7:0] e, input string nm);
		xfer(1'b0, idx, 8'h00);
		chk(nm, e, rd);
	endtask : rchk
	task automatic nap;
		start <= 1'b1;
		@(posedge hclk);
		start <= 1'b0;
		@(posedge hclk);
		while (cpu_idle === 1'b1) @(posedge hclk);
		repeat (2) @(posedge hclk);
	endtask : nap
	task automatic unlock;
		xfer(1'b1, flash_isp_pkg::IDX_UNLOCK_KEY, flash_isp_pkg::KEY_FIRST);
		xfer(1'b1, flash_isp_pkg::IDX_UNLOCK_KEY, flash_isp_pkg::KEY_SECOND);
	endtask : unlock
	task automatic fetch_chk(input logic [7:0] e);
		fetch_addr <= 16'h0003;
		repeat (3) @(posedge hclk);
		chk("fetch", e, fetch_data);
	endtask : fetch_chk

	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	initial begin
		repeat (3000) @(posedge hclk);
		miscompares++;
		close_out();
	end
	initial begin
		{miscompares, num_checks} = '0;
		{hresetn, hwrite, start, htrans, haddr, hwdata, fetch_addr} = '0;
		hsel = 1'b1;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h00, "mode");
		rchk(flash_isp_pkg::IDX_OP_CONTROL, 8'h00, "opctl");
		rchk(10'h010, 8'h00, "unmapped");
		xfer(1'b1, flash_isp_pkg::IDX_MODE_CONTROL, 8'h01);
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h00, "mode");
		xfer(1'b1, flash_isp_pkg::IDX_UNLOCK_KEY, flash_isp_pkg::KEY_FIRST);
		xfer(1'b1, flash_isp_pkg::IDX_UNLOCK_KEY, 8'h00);
		xfer(1'b1, flash_isp_pkg::IDX_UNLOCK_KEY, flash_isp_pkg::KEY_SECOND);
		xfer(1'b1, flash_isp_pkg::IDX_MODE_CONTROL, 8'h01);
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h00, "mode");
		unlock();
		xfer(1'b1, flash_isp_pkg::IDX_MODE_CONTROL, 8'h01);
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h01, "mode");
		xfer(1'b1, flash_isp_pkg::IDX_UNLOCK_KEY, 8'h00);
		xfer(1'b1, flash_isp_pkg::IDX_MODE_CONTROL, 8'h03);
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h01, "mode");
		xfer(1'b1, flash_isp_pkg::IDX_ADDR_HIGH, 8'h00);
		xfer(1'b1, flash_isp_pkg::IDX_ADDR_LOW, 8'h05);
		xfer(1'b1, flash_isp_pkg::IDX_PROG_DATA, 8'hA5);
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h21);
		nap();
		rchk(flash_isp_pkg::IDX_STATUS, 8'h06, "status");
		chk("loader", 8'h01, {7'h00, loader_fetch});
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h21, "mode");
		xfer(1'b1, flash_isp_pkg::IDX_STATUS, 8'h02);
		rchk(flash_isp_pkg::IDX_STATUS, 8'h04, "status");
		xfer(1'b1, flash_isp_pkg::IDX_PROG_DATA, 8'h00);
		// Chip enable high is not a legal program command: nothing runs
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h31);
		nap();
		rchk(flash_isp_pkg::IDX_STATUS, 8'h04, "status");
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h00);
		nap();
		rchk(flash_isp_pkg::IDX_PROG_DATA, 8'hA5, "data");
		xfer(1'b1, flash_isp_pkg::IDX_ADDR_LOW, 8'h03);
		xfer(1'b1, flash_isp_pkg::IDX_PROG_DATA, 8'h3C);
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h61);
		nap();
		fetch_chk(8'h3C);
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h62);
		nap();
		fetch_chk(8'hFF);
		xfer(1'b1, flash_isp_pkg::IDX_ADDR_LOW, 8'h05);
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h00);
		nap();
		rchk(flash_isp_pkg::IDX_PROG_DATA, 8'hA5, "data");
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h22);
		nap();
		xfer(1'b1, flash_isp_pkg::IDX_OP_CONTROL, 8'h00);
		nap();
		rchk(flash_isp_pkg::IDX_PROG_DATA, 8'hFF, "data");
		unlock();
		xfer(1'b1, flash_isp_pkg::IDX_MODE_CONTROL, 8'h83);
		nap();
		chk("loader", 8'h00, {7'h00, loader_fetch});
		rchk(flash_isp_pkg::IDX_MODE_CONTROL, 8'h00, "mode");
		rchk(flash_isp_pkg::IDX_STATUS, 8'h00, "status");
		close_out();
	end
endmodule : testbench
